// file: rtl/tsreg_pkg.sv
`default_nettype none
package tsreg_pkg;

    localparam int TSREG_AW = 8;
    localparam int TSREG_DW = 32;

    // Register numbers
    localparam logic [7:0] TSREG_BOOT_STATUS   = 8'h03;
    localparam logic [7:0] TSREG_SECURITY      = 8'h05;
    localparam logic [7:0] TSREG_RO_CONTROL    = 8'h06;
    localparam logic [7:0] TSREG_CNT_TILE_CELL = 8'h07;
    localparam logic [7:0] TSREG_CNT_TILE_WIRE = 8'h08;
    localparam logic [7:0] TSREG_CNT_PER_CELL  = 8'h09;
    localparam logic [7:0] TSREG_CNT_PER_WIRE  = 8'h0a;
    localparam logic [7:0] TSREG_RAM_SIZE      = 8'h0c;
    localparam logic [7:0] TSREG_DBG_STATUS    = 8'h10;
    localparam logic [7:0] TSREG_DBG_PC        = 8'h11;

    // Boot status fields
    localparam int TSREG_BS_PROC_LSB  = 16;
    localparam int TSREG_BS_OVR_BIT   = 8;
    localparam int TSREG_BS_CORE_OFF  = 5;
    localparam int TSREG_BS_NO_POLL   = 4;
    localparam int TSREG_BS_FROM_RAM  = 3;
    localparam int TSREG_BS_FROM_JTAG = 2;

    // Security fields
    localparam int TSREG_SEC_WLOCK     = 31;
    localparam int TSREG_SEC_GDBG_OFF  = 14;
    localparam int TSREG_SEC_LOCK_ALL  = 12;
    localparam int TSREG_SEC_LOCK_LSB  = 8;
    localparam int TSREG_SEC_OTP_BOOT  = 5;
    localparam int TSREG_SEC_JCFG_OFF  = 4;
    localparam int TSREG_SEC_TAP_OFF   = 0;
    localparam logic [31:0] TSREG_SEC_MASK = 32'h8000_5fb1;
    localparam logic [31:0] TSREG_SEC_RST  = 32'h0000_0000;

    // Ring oscillator control fields
    localparam int TSREG_RO_CORE_BIT = 1;
    localparam int TSREG_RO_PER_BIT  = 0;
    localparam logic [1:0] TSREG_RO_RST = 2'h0;
    localparam int TSREG_RO_SETTLE_CYCLES = 10;

    // Saved status: captured bits and debug-writable bits
    localparam logic [10:0] TSREG_DST_CAP_MASK = 11'h7df;
    localparam logic [10:0] TSREG_DST_WR_MASK  = 11'h6df;
    localparam logic [10:0] TSREG_DST_RST      = 11'h000;
    localparam logic [31:0] TSREG_DPC_RST      = 32'h0000_0000;

endpackage : tsreg_pkg
`default_nettype wire

// file: rtl/tsreg_top.sv
`default_nettype none
module tsreg_top #(
    parameter int          CNT_W     = 16,
    parameter logic [31:0] RAM_BYTES = 32'h0004_0000
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                ce,
    input  wire logic                ps_wr,
    input  wire logic                ps_rd,
    input  wire logic [tsreg_pkg::TSREG_AW-1:0] ps_addr,
    input  wire logic [tsreg_pkg::TSREG_DW-1:0] ps_wdata,
    output logic      [tsreg_pkg::TSREG_DW-1:0] ps_rdata,
    output logic                     ps_rvalid,
    input  wire logic                debug_mode,
    input  wire logic [7:0]          proc_num,
    input  wire logic [1:0]          boot_pll_mode_pins,
    input  wire logic                boot_from_ram,
    input  wire logic                boot_from_jtag,
    input  wire logic                skip_otp_poll,
    input  wire logic                second_core_off,
    input  wire logic                otp_load,
    input  wire logic [31:0]         otp_security_word,
    input  wire logic [3:0]          ring_tick,
    input  wire logic                dbg_entry,
    input  wire logic [10:0]         thread_status,
    input  wire logic [31:0]         thread_pc,
    output logic                     global_debug_block,
    output logic [3:0]               otp_sector_lock,
    output logic                     force_otp_boot,
    output logic                     jtag_cfg_block,
    output logic                     jtag_tap_block,
    output logic                     core_ring_run,
    output logic                     periph_ring_run
);
    import tsreg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    function automatic logic [31:0] masked_merge(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [31:0] m);
        masked_merge = (old_v & ~m) | (new_v & m);
    endfunction : masked_merge

    ////////////////////////////////////////////////////////////////////////
    logic [1:0]       pll_mode_reg;
    logic [31:0]      sec_reg;
    logic [31:0]      sec_next;
    logic [1:0]       ro_ctrl_reg;
    logic [1:0]       ro_ctrl_next;
    // Counters start at zero at power-up and are never reset afterwards
    logic [CNT_W-1:0] cnt_reg [4] = '{default: '0};
    logic [10:0]      dst_reg;
    logic [10:0]      dst_next;
    logic [31:0]      dpc_reg;
    logic [31:0]      dpc_next;
    logic [31:0]      rd_mux;
    logic [31:0]      boot_word;
    logic [3:0]       ring_en;

    wire wr_sec  = ps_wr && hit(ps_addr, TSREG_SECURITY);
    wire wr_ctrl = ps_wr && hit(ps_addr, TSREG_RO_CONTROL);
    wire wr_dst  = ps_wr && debug_mode && hit(ps_addr, TSREG_DBG_STATUS);
    wire wr_dpc  = ps_wr && debug_mode && hit(ps_addr, TSREG_DBG_PC);
    wire sec_wlocked = sec_reg[TSREG_SEC_WLOCK];

    ////////////////////////////////////////////////////////////////////////
    // Boot status, pins sampled while reset is held
    always_ff @(posedge clk) begin
        if (ce && sys_rst) begin
            pll_mode_reg <= boot_pll_mode_pins;
        end
    end

    always_comb begin
        boot_word = 32'h0000_0000;
        boot_word[TSREG_BS_PROC_LSB +: 8] = proc_num;
        boot_word[TSREG_BS_OVR_BIT] = sec_reg[TSREG_SEC_OTP_BOOT];
        boot_word[TSREG_BS_CORE_OFF] = second_core_off;
        boot_word[TSREG_BS_NO_POLL] = skip_otp_poll;
        boot_word[TSREG_BS_FROM_RAM] = boot_from_ram;
        boot_word[TSREG_BS_FROM_JTAG] = boot_from_jtag;
        boot_word[1:0] = pll_mode_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Security word: OTP load always wins, software only while unlocked
    always_comb begin
        sec_next = sec_reg;
        if (otp_load) begin
            sec_next = otp_security_word & TSREG_SEC_MASK;
        end else if (wr_sec && !sec_wlocked) begin
            sec_next = masked_merge(sec_reg, ps_wdata, TSREG_SEC_MASK);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sec_reg <= TSREG_SEC_RST;
        end else if (ce) begin
            sec_reg <= sec_next;
        end
    end

    assign global_debug_block = sec_reg[TSREG_SEC_GDBG_OFF];
    assign otp_sector_lock = sec_reg[TSREG_SEC_LOCK_LSB +: 4]
                           | {4{sec_reg[TSREG_SEC_LOCK_ALL]}};
    assign force_otp_boot = sec_reg[TSREG_SEC_OTP_BOOT];
    assign jtag_cfg_block = sec_reg[TSREG_SEC_JCFG_OFF];
    assign jtag_tap_block = sec_reg[TSREG_SEC_TAP_OFF];

    ////////////////////////////////////////////////////////////////////////
    // Ring oscillator control and counters
    assign ro_ctrl_next = wr_ctrl ? ps_wdata[1:0] : ro_ctrl_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ro_ctrl_reg <= TSREG_RO_RST;
        end else if (ce) begin
            ro_ctrl_reg <= ro_ctrl_next;
        end
    end

    assign core_ring_run   = ro_ctrl_reg[TSREG_RO_CORE_BIT];
    assign periph_ring_run = ro_ctrl_reg[TSREG_RO_PER_BIT];
    assign ring_en = {periph_ring_run, periph_ring_run,
                      core_ring_run, core_ring_run};

    // Each oscillator edge arrives as a tick; counters have no reset
    for (genvar i = 0; i < 4; i++) begin : g_cnt
        always_ff @(posedge clk) begin
            if (ce && ring_en[i] && ring_tick[i]) begin
                cnt_reg[i] <= cnt_reg[i] + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debug snapshots: capture at entry, debugger writes in debug mode
    always_comb begin
        dst_next = dst_reg;
        dpc_next = dpc_reg;
        if (dbg_entry) begin
            dst_next = thread_status & TSREG_DST_CAP_MASK;
            dpc_next = thread_pc;
        end else begin
            if (wr_dst) begin
                dst_next = (dst_reg & ~TSREG_DST_WR_MASK)
                         | (ps_wdata[10:0] & TSREG_DST_WR_MASK);
            end
            if (wr_dpc) begin
                dpc_next = ps_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dst_reg <= TSREG_DST_RST;
            dpc_reg <= TSREG_DPC_RST;
        end else if (ce) begin
            dst_reg <= dst_next;
            dpc_reg <= dpc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path; unmapped numbers return zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (ps_addr)
            TSREG_BOOT_STATUS:   rd_mux = boot_word;
            TSREG_SECURITY:      rd_mux = sec_reg;
            TSREG_RO_CONTROL:    rd_mux = {30'h0, ro_ctrl_reg};
            TSREG_CNT_TILE_CELL: rd_mux = 32'(cnt_reg[0]);
            TSREG_CNT_TILE_WIRE: rd_mux = 32'(cnt_reg[1]);
            TSREG_CNT_PER_CELL:  rd_mux = 32'(cnt_reg[2]);
            TSREG_CNT_PER_WIRE:  rd_mux = 32'(cnt_reg[3]);
            TSREG_RAM_SIZE:      rd_mux = {RAM_BYTES[31:2], 2'h0};
            TSREG_DBG_STATUS:    rd_mux = {21'h0, dst_reg};
            TSREG_DBG_PC:        rd_mux = dpc_reg;
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ps_rdata  <= 32'h0000_0000;
            ps_rvalid <= 1'b0;
        end else if (ce) begin
            ps_rvalid <= ps_rd;
            if (ps_rd) begin
                ps_rdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_rd(logic [7:0] r);
        ce && ps_rd && ps_addr == r;
    endsequence

    sequence s_core_stopped;
        (ce && !core_ring_run) [*2];
    endsequence

    AST_BOOT_FIELDS: assert property (
        s_rd(TSREG_BOOT_STATUS) |=>
            ps_rdata[23:16] == $past(proc_num) && ps_rdata[31:24] == 8'h00
            && ps_rdata[8] == $past(force_otp_boot))
        else $error("boot status fields wrong");

    AST_BOOT_STRAPS: assert property (
        s_rd(TSREG_BOOT_STATUS) |=>
            ps_rdata[5:2] == $past({second_core_off, skip_otp_poll,
                                    boot_from_ram, boot_from_jtag}))
        else $error("boot status strap bits wrong");

    AST_SEC_LOCKED: assert property (
        ce && sec_wlocked && wr_sec && !otp_load |=> $stable(sec_reg))
        else $error("locked security word changed by write");

    AST_SEC_LOAD: assert property (
        ce && otp_load |=> sec_reg == ($past(otp_security_word)
                                       & TSREG_SEC_MASK))
        else $error("security word not loaded from otp");

    AST_SECTOR_LOCK: assert property (
        ce && otp_load && otp_security_word[TSREG_SEC_LOCK_ALL] |=>
            otp_sector_lock == 4'hf)
        else $error("lock all did not lock every sector");

    AST_CORE_FROZEN: assert property (
        s_core_stopped |-> $stable(cnt_reg[0]) && $stable(cnt_reg[1]))
        else $error("core counter moved while stopped");

    AST_CTRL_WRITE: assert property (
        ce && wr_ctrl |=> periph_ring_run == $past(ps_wdata[0])
                          && core_ring_run == $past(ps_wdata[1]))
        else $error("ring control write not applied");

    AST_CNT_UPPER: assert property (
        s_rd(TSREG_CNT_PER_WIRE) |=> ps_rdata[31:16] == 16'h0000
                                     && ps_rdata[15:0] == $past(cnt_reg[3]))
        else $error("counter readback wrong");

    AST_RAM_SIZE: assert property (
        s_rd(TSREG_RAM_SIZE) |=> ps_rdata == {RAM_BYTES[31:2], 2'h0})
        else $error("ram size readback wrong");

    AST_DBG_CAPTURE: assert property (
        ce && dbg_entry |=> dst_reg == ($past(thread_status)
                                        & TSREG_DST_CAP_MASK)
                            && dpc_reg == $past(thread_pc))
        else $error("debug snapshot not captured");

    AST_DST_RO_BIT: assert property (
        ce && wr_dst && !dbg_entry |=> dst_reg[8] == $past(dst_reg[8])
                                       && dst_reg[5] == 1'b0)
        else $error("read-only saved status bit written");

endmodule : tsreg_top
`default_nettype wire

// file: sim/tile_status_security_regs_bench.sv
`default_nettype none
module tile_status_security_regs_bench
    import tsreg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] RAM_B = 32'h0003_0007;
    logic        clk, sys_rst, ce, ps_wr, ps_rd, ps_rvalid, debug_mode;
    logic        boot_from_ram, boot_from_jtag, skip_otp_poll;
    logic        second_core_off, otp_load, dbg_entry, global_debug_block;
    logic        force_otp_boot, jtag_cfg_block, jtag_tap_block;
    logic        core_ring_run, periph_ring_run;
    logic [7:0]  ps_addr, proc_num;
    logic [31:0] ps_wdata, ps_rdata, otp_security_word, thread_pc;
    logic [1:0]  boot_pll_mode_pins, pins, mode;
    logic [3:0]  ring_tick, otp_sector_lock;
    logic [10:0] thread_status, cap;
    logic [31:0] rs, sec, last_rdata, w, m_e, m_m;
    logic [15:0] cnt [4];
    logic [31:0] exp_q [$];
    logic [31:0] msk_q [$];
    int          err_count, total_checks;

    tsreg_top #(.CNT_W(16), .RAM_BYTES(RAM_B)) u_dut (
        .clk, .sys_rst, .ce, .ps_wr, .ps_rd, .ps_addr, .ps_wdata,
        .ps_rdata, .ps_rvalid, .debug_mode, .proc_num, .boot_pll_mode_pins,
        .boot_from_ram, .boot_from_jtag, .skip_otp_poll, .second_core_off,
        .otp_load, .otp_security_word, .ring_tick, .dbg_entry,
        .thread_status, .thread_pc, .global_debug_block, .otp_sector_lock,
        .force_otp_boot, .jtag_cfg_block, .jtag_tap_block, .core_ring_run,
        .periph_ring_run);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd

    function automatic logic [31:0] boot_exp();
        return {8'h00, proc_num, 7'h00, sec[5], 2'b00, second_core_off,
                skip_otp_poll, boot_from_ram, boot_from_jtag, pins};
    endfunction : boot_exp

    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    task automatic check(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        step();
        ps_wr = 1'b1;
        ps_addr = a;
        ps_wdata = d;
        step();
        ps_wr = 1'b0;
    endtask : wr

    // Notes the expectation, issues the read, waits for the answer
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        int n;
        step();
        exp_q.push_back(e);
        msk_q.push_back(m);
        ps_rd = 1'b1;
        ps_addr = a;
        step();
        ps_rd = 1'b0;
        n = 0;
        while (exp_q.size() != 0 && n < 20) begin
            step();
            n++;
        end
        if (exp_q.size() != 0) begin
            err_count++;
            print_verdict();
        end
    endtask : rd

    task automatic sec_chk();
        logic [7:0] e;
        e = {sec[14], sec[11:8] | {4{sec[12]}}, sec[5], sec[4], sec[0]};
        check("sec_out", {24'h0, global_debug_block, otp_sector_lock,
              force_otp_boot, jtag_cfg_block, jtag_tap_block}, {24'h0, e});
    endtask : sec_chk

    always @(posedge clk) begin
        #2;
        if (ps_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("rvalid", 32'h1, 32'h0);
            end else begin
                last_rdata = ps_rdata;
                m_e = exp_q.pop_front();
                m_m = msk_q.pop_front();
                check("rdata", ps_rdata & m_m, m_e & m_m);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rs = 32'd76220;
        {ps_wr, ps_rd, otp_load, dbg_entry, debug_mode} = '0;
        ps_addr = '0;
        ps_wdata = '0;
        otp_security_word = '0;
        thread_pc = '0;
        thread_status = '0;
        ring_tick = '0;
        sec = '0;
        ce = 1'b1;
        sys_rst = 1'b1;
        w = rnd();
        {proc_num, boot_from_ram, boot_from_jtag, skip_otp_poll} = w[10:0];
        {second_core_off, pins} = w[13:11];
        boot_pll_mode_pins = pins;
        repeat (12) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        boot_pll_mode_pins = ~pins;
        rd(TSREG_BOOT_STATUS, boot_exp(), '1);
        wr(TSREG_BOOT_STATUS, '1);
        rd(TSREG_BOOT_STATUS, boot_exp(), '1);
        rd(8'h04, 32'h0, '1);
        rd(TSREG_RAM_SIZE, RAM_B & 32'hffff_fffc, '1);
        rd(TSREG_RO_CONTROL, 32'h0, '1);
        for (int i = 0; i < 3; i++) begin
            step();
            otp_load = 1'b1;
            otp_security_word = rnd() & 32'h7fff_ffff;
            sec = otp_security_word & TSREG_SEC_MASK;
            step();
            otp_load = 1'b0;
            step();
            sec_chk();
            rd(TSREG_SECURITY, sec, '1);
            w = rnd() & 32'h7fff_ffff;
            wr(TSREG_SECURITY, w);
            sec = w & TSREG_SEC_MASK;
            rd(TSREG_SECURITY, sec, '1);
            rd(TSREG_BOOT_STATUS, boot_exp(), '1);
        end
        w = rnd() | 32'h8000_0000;
        wr(TSREG_SECURITY, w);
        sec = w & TSREG_SEC_MASK;
        wr(TSREG_SECURITY, ~w);
        rd(TSREG_SECURITY, sec, '1);
        sec_chk();
        for (int md = 0; md < 4; md++) begin
            mode = md[1:0];
            wr(TSREG_RO_CONTROL, (rnd() & 32'hffff_fffc) | 32'(md));
            step();
            check("ring_run", {30'h0, core_ring_run, periph_ring_run},
                  32'(md));
            rd(TSREG_RO_CONTROL, 32'(md), '1);
            for (int i = 0; i < 4; i++) begin
                rd(TSREG_CNT_TILE_CELL + 8'(i), 32'h0, 32'hffff_0000);
                cnt[i] = last_rdata[15:0];
            end
            for (int k = 0; k < 24; k++) begin
                step();
                w = rnd();
                ring_tick = w[3:0];
                for (int i = 0; i < 4; i++)
                    if (w[i] && mode[i < 2 ? 1 : 0]) cnt[i]++;
            end
            step();
            ring_tick = 4'h0;
            wr(TSREG_RO_CONTROL, 32'h0);
            repeat (10) step();
            for (int i = 0; i < 4; i++)
                rd(TSREG_CNT_TILE_CELL + 8'(i), {16'h0, cnt[i]}, '1);
        end
        sys_rst = 1'b1;
        repeat (2) step();
        sys_rst = 1'b0;
        sec = '0;
        pins = ~pins;
        for (int i = 0; i < 4; i++)
            rd(TSREG_CNT_TILE_CELL + 8'(i), {16'h0, cnt[i]}, '1);
        rd(TSREG_SECURITY, 32'h0, '1);
        rd(TSREG_BOOT_STATUS, boot_exp(), '1);
        ce = 1'b0;
        wr(TSREG_RO_CONTROL, 32'h3);
        ce = 1'b1;
        rd(TSREG_RO_CONTROL, 32'h0, '1);
        wr(TSREG_DBG_PC, rnd());
        rd(TSREG_DBG_PC, 32'h0, '1);
        step();
        w = rnd();
        dbg_entry = 1'b1;
        thread_status = w[10:0];
        thread_pc = rnd();
        cap = w[10:0] & 11'h7df;
        step();
        dbg_entry = 1'b0;
        thread_status = ~thread_status;
        rd(TSREG_DBG_STATUS, {21'h0, cap}, '1);
        rd(TSREG_DBG_PC, thread_pc, '1);
        debug_mode = 1'b1;
        w = rnd();
        wr(TSREG_DBG_STATUS, w);
        cap = (cap & 11'h100) | (w[10:0] & 11'h6df);
        rd(TSREG_DBG_STATUS, {21'h0, cap}, '1);
        wr(TSREG_DBG_PC, ~w);
        rd(TSREG_DBG_PC, ~w, '1);
        print_verdict();
    end
endmodule : tile_status_security_regs_bench
`default_nettype wire
